// *** fbci_pkg.sv ***
// Package: command codes, pin timing and identifier addresses for the flash host controller
package fbci_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
    localparam logic [19:0] IDENT_MFR_ADDR = 20'h00000;
    localparam logic [19:0] IDENT_DEV_ADDR = 20'h00001;
    localparam int CLK_MHZ = 200;
    // Pin timing in ns
    localparam int WAKE_WRITE_NS = 1000;
    localparam int WAKE_READ_NS = 400;
    localparam int STROBE_NS = 60;
    localparam int ACCESS_NS = 120;
    localparam int HOLD_NS = 20;
    localparam int WAKE_WRITE_CYC = (WAKE_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_READ_CYC = (WAKE_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_SLEEP,
        OP_WAKE,
        OP_NONE
    } fbci_op_t;
endpackage

// *** fbci_tmr_if.sv ***
// Interface: wait timer load and expiry between controller and its timer
`timescale 1ns/1ps
interface fbci_tmr_if;
    logic load;
    logic [fbci_pkg::CNT_W-1:0] count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// *** fbci_timer.sv ***
// Module: down counter that marks the end of a loaded wait
`timescale 1ns/1ps
module fbci_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Load and expiry
    fbci_tmr_if.tmr t
);
    logic [fbci_pkg::CNT_W-1:0] cnt_r, cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (t.load) begin
            cnt_nxt = t.count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Expiry comes from the register alone, so a caller that reloads on expiry forms no loop
    assign t.done = (cnt_r == '0);
endmodule

// *** fbci_host.sv ***
// Module: host bus controller that drives the byte-wide flash through its pins
`timescale 1ns/1ps
module fbci_host #(
    parameter int WAKE_WRITE_CYC = fbci_pkg::WAKE_WRITE_CYC,
    parameter int WAKE_READ_CYC = fbci_pkg::WAKE_READ_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire fbci_pkg::fbci_op_t req_op,
    input wire logic [fbci_pkg::ADDR_W-1:0] req_addr,
    input wire logic [fbci_pkg::DATA_W-1:0] req_wdata,
    // User answer
    output logic rsp_valid,
    output logic [fbci_pkg::DATA_W-1:0] rsp_rdata,
    output logic engine_busy,
    output logic asleep,
    // Flash pins
    output logic chip_sel_n,
    output logic out_drv_n,
    output logic wr_strobe_n,
    output logic deep_sleep_n,
    output logic [fbci_pkg::ADDR_W-1:0] addr_pins,
    output logic [fbci_pkg::DATA_W-1:0] data_pins_o,
    output logic data_pins_oe_n,
    input wire logic [fbci_pkg::DATA_W-1:0] data_pins_i,
    input wire logic op_done_flag
);
    localparam logic [fbci_pkg::CNT_W-1:0] STB_C = fbci_pkg::CNT_W'(fbci_pkg::STROBE_CYC);
    localparam logic [fbci_pkg::CNT_W-1:0] ACC_C = fbci_pkg::CNT_W'(fbci_pkg::ACCESS_CYC);
    localparam logic [fbci_pkg::CNT_W-1:0] HLD_C = fbci_pkg::CNT_W'(fbci_pkg::HOLD_CYC);
    localparam logic [fbci_pkg::CNT_W-1:0] WW_C = fbci_pkg::CNT_W'(WAKE_WRITE_CYC);
    localparam logic [fbci_pkg::CNT_W-1:0] WR_C = fbci_pkg::CNT_W'(WAKE_READ_CYC);

    // Both wake delays must fit the timer width
    if (WAKE_WRITE_CYC < 1 || WAKE_WRITE_CYC >= (1 << fbci_pkg::CNT_W) ||
        WAKE_READ_CYC < 1 || WAKE_READ_CYC >= (1 << fbci_pkg::CNT_W)) begin : g_bad_wake
        $error("wake delay out of timer range");
    end

    typedef enum {
        ST_IDLE,
        ST_RD_ACC,
        ST_WR_STB,
        ST_WR_HOLD,
        ST_SLEEP,
        ST_WAKE
    } fbci_st_t;

    fbci_st_t st_r, st_nxt;
    logic cs_n_r, cs_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, rp_n_r, rp_n_nxt;
    logic drv_n_r, drv_n_nxt, rsp_r, rsp_nxt;
    logic rd_block_r, rd_block_nxt, wr_block_r, wr_block_nxt;
    logic [fbci_pkg::ADDR_W-1:0] a_r, a_nxt;
    logic [fbci_pkg::DATA_W-1:0] d_r, d_nxt, q_r, q_nxt;
    logic [fbci_pkg::DATA_W-1:0] din_s1_r, din_s2_r;
    logic rdy_s1_r, rdy_s2_r;
    fbci_tmr_if tif ();
    fbci_tmr_if wif ();

    fbci_timer u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .t(tif)
    );

    fbci_timer u_wake_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .t(wif)
    );

    // Two-stage synchronisers on the pins coming back from the flash
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
            rdy_s1_r <= 1'b1;
            rdy_s2_r <= 1'b1;
        end else begin
            din_s1_r <= data_pins_i;
            din_s2_r <= din_s1_r;
            rdy_s1_r <= op_done_flag;
            rdy_s2_r <= rdy_s1_r;
        end
    end

    // Sleep is accepted whenever idle or asleep; reads wait out wake read delay, writes the longer one.
    // Pin cycles are refused while asleep: the caller must wake the part first.
    assign req_ready = (st_r == ST_IDLE || st_r == ST_SLEEP) &&
        !(st_r == ST_SLEEP && req_op inside {fbci_pkg::OP_READ, fbci_pkg::OP_WRITE}) &&
        !(req_op == fbci_pkg::OP_WRITE && wr_block_r) &&
        !(req_op == fbci_pkg::OP_READ && rd_block_r);

    always_comb begin
        st_nxt = st_r;
        cs_n_nxt = cs_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        rp_n_nxt = rp_n_r;
        drv_n_nxt = drv_n_r;
        rsp_nxt = 1'b0;
        rd_block_nxt = rd_block_r;
        wr_block_nxt = wr_block_r;
        a_nxt = a_r;
        d_nxt = d_r;
        q_nxt = q_r;
        tif.load = 1'b0;
        tif.count = '0;
        wif.load = 1'b0;
        wif.count = '0;
        if (wif.done) begin
            wr_block_nxt = 1'b0;
        end
        case (st_r)
            ST_IDLE, ST_SLEEP: begin
                if (req_valid && req_ready) begin
                    a_nxt = req_addr;
                    d_nxt = req_wdata;
                    case (req_op)
                        fbci_pkg::OP_READ: begin
                            // Strobe stays high and the host floats before drive goes low
                            cs_n_nxt = 1'b0;
                            oe_n_nxt = 1'b0;
                            drv_n_nxt = 1'b1;
                            tif.load = 1'b1;
                            tif.count = ACC_C;
                            st_nxt = ST_RD_ACC;
                        end
                        fbci_pkg::OP_WRITE: begin
                            // Any command byte passes; the caller owns code choice
                            cs_n_nxt = 1'b0;
                            oe_n_nxt = 1'b1;
                            we_n_nxt = 1'b0;
                            drv_n_nxt = 1'b0;
                            tif.load = 1'b1;
                            tif.count = STB_C;
                            st_nxt = ST_WR_STB;
                        end
                        fbci_pkg::OP_SLEEP: begin
                            // Aborts any running erase or program
                            rp_n_nxt = 1'b0;
                            cs_n_nxt = 1'b1;
                            oe_n_nxt = 1'b1;
                            rsp_nxt = 1'b1;
                            st_nxt = ST_SLEEP;
                        end
                        fbci_pkg::OP_WAKE: begin
                            rp_n_nxt = 1'b1;
                            rd_block_nxt = 1'b1;
                            wr_block_nxt = 1'b1;
                            tif.load = 1'b1;
                            tif.count = WR_C;
                            // Own timer, so a read soon after wake cannot shorten the write delay
                            wif.load = 1'b1;
                            wif.count = WW_C;
                            rsp_nxt = 1'b1;
                            st_nxt = ST_WAKE;
                        end
                        default: begin
                            rsp_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_WAKE: begin
                if (tif.done) begin
                    rd_block_nxt = 1'b0;
                    st_nxt = ST_IDLE;
                end
            end
            ST_RD_ACC: begin
                if (tif.done) begin
                    q_nxt = din_s2_r;
                    cs_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    rsp_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            ST_WR_STB: begin
                if (tif.done) begin
                    // Device latches address and data on this rising edge
                    we_n_nxt = 1'b1;
                    tif.load = 1'b1;
                    tif.count = HLD_C;
                    st_nxt = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                if (tif.done) begin
                    cs_n_nxt = 1'b1;
                    drv_n_nxt = 1'b1;
                    rsp_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_IDLE;
            cs_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            rp_n_r <= 1'b1;
            drv_n_r <= 1'b1;
            rsp_r <= 1'b0;
            rd_block_r <= 1'b0;
            wr_block_r <= 1'b0;
            a_r <= '0;
            d_r <= '0;
            q_r <= '0;
        end else begin
            st_r <= st_nxt;
            cs_n_r <= cs_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            rp_n_r <= rp_n_nxt;
            drv_n_r <= drv_n_nxt;
            rsp_r <= rsp_nxt;
            rd_block_r <= rd_block_nxt;
            wr_block_r <= wr_block_nxt;
            a_r <= a_nxt;
            d_r <= d_nxt;
            q_r <= q_nxt;
        end
    end

    assign chip_sel_n = cs_n_r;
    assign out_drv_n = oe_n_r;
    assign wr_strobe_n = we_n_r;
    assign deep_sleep_n = rp_n_r;
    assign addr_pins = a_r;
    assign data_pins_o = d_r;
    assign data_pins_oe_n = drv_n_r;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = q_r;
    // Busy as seen by the flash; forced idle while the host holds it asleep
    assign engine_busy = rp_n_r && !rdy_s2_r;
    assign asleep = !rp_n_r;

    a_no_contend: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !out_drv_n |-> data_pins_oe_n) else $error("host drives data during read");
    a_read_pins: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!out_drv_n && !chip_sel_n) |-> (wr_strobe_n && deep_sleep_n))
        else $error("read without strobe and sleep high");
    a_write_sel: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !wr_strobe_n |-> (!chip_sel_n && !data_pins_oe_n && out_drv_n))
        else $error("strobe low without select and data");

    sequence s_wake;
        $rose(deep_sleep_n);
    endsequence
    a_wake_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_wake |-> wr_strobe_n [*8]) else $error("write too soon after wake");
    a_wake_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_wake |-> out_drv_n [*2]) else $error("read too soon after wake");
    a_sleep_desel: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(deep_sleep_n) |-> (chip_sel_n && out_drv_n && !engine_busy))
        else $error("sleep without deselect");
    a_strobe_stable: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!wr_strobe_n && !$past(wr_strobe_n)) |-> ($stable(addr_pins) && $stable(data_pins_o)))
        else $error("address or data moved under strobe");
    a_read_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(out_drv_n) |-> ##[1:40] rsp_valid) else $error("read never answered");
endmodule

// *** fbci_flash_model.sv ***
// Behavioural flash device that answers the host controller pins
`timescale 1ns/1ps
module fbci_flash_model #(
    parameter int BUSY_STEPS = 40,
    parameter logic [7:0] MFR_CODE = 8'h6E,
    parameter logic [7:0] DEV_CODE = 8'h1D
) (
    // Control pins
    input wire logic chip_sel_n,
    input wire logic out_drv_n,
    input wire logic wr_strobe_n,
    input wire logic deep_sleep_n,
    input wire logic program_supply_high,
    // Address and data
    input wire logic [19:0] addr_pins,
    input wire logic [7:0] data_pins,
    output logic [7:0] dev_q,
    output logic dev_drv,
    // Engine state
    output logic op_done_flag
);
    logic [7:0] mem [256];
    logic [1:0] mode;
    logic erase_p, prog_p, busy, susp;
    int left;
    task go();
        busy = 1'b1;
        left = BUSY_STEPS;
    endtask
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {mode, erase_p, prog_p, busy, susp} = '0;
    end
    assign op_done_flag = !busy || susp;
    assign dev_drv = !chip_sel_n && !out_drv_n && deep_sleep_n && wr_strobe_n;
    always_comb begin
        case (mode)
            2'h1: dev_q = addr_pins[0] ? DEV_CODE : MFR_CODE;
            2'h2: dev_q = {op_done_flag, 7'h00};
            default: dev_q = mem[addr_pins[7:0]];
        endcase
    end
    // Only the strobe edge latches; the latch claims no address
    always @(posedge wr_strobe_n) begin
        if (!chip_sel_n && deep_sleep_n) begin
            if (prog_p) begin
                prog_p = 1'b0;
                if (program_supply_high) begin
                    mem[addr_pins[7:0]] &= data_pins;
                    go();
                end
            end else if (erase_p) begin
                erase_p = 1'b0;
                if (program_supply_high && data_pins == fbci_pkg::CMD_CONFIRM) begin
                    foreach (mem[i]) mem[i] = 8'hFF;
                    go();
                end
            end else begin
                case (data_pins)
                    fbci_pkg::CMD_READ_ARRAY: mode = 2'h0;
                    fbci_pkg::CMD_IDENT: mode = 2'h1;
                    fbci_pkg::CMD_READ_STATUS: mode = 2'h2;
                    fbci_pkg::CMD_CLEAR_STATUS: ;
                    fbci_pkg::CMD_ERASE_SETUP: erase_p = 1'b1;
                    fbci_pkg::CMD_PROG_SETUP, fbci_pkg::CMD_PROG_SETUP_ALT: prog_p = 1'b1;
                    fbci_pkg::CMD_SUSPEND: {susp, mode} = {busy, 2'h2};
                    fbci_pkg::CMD_CONFIRM: susp = 1'b0;
                    default: ;
                endcase
            end
        end
    end
    // Engine time runs whether or not the part is selected
    always #10 begin
        if (busy && !susp) begin
            busy = left > 0;
            left = left - 1;
        end
    end
    // Abort leaves the target byte as it stood; the host must not trust it
    always @(negedge deep_sleep_n) begin
        {busy, susp, erase_p, prog_p, mode} = '0;
    end
endmodule

// *** fbci_host_tb.sv ***
// Testbench: host controller against the behavioural flash model
`timescale 1ns/1ps
module fbci_host_tb;
    localparam logic [7:0] MFR = 8'h6E;
    localparam logic [7:0] DEV = 8'h1D;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    fbci_pkg::fbci_op_t req_op = fbci_pkg::OP_NONE;
    logic [19:0] req_addr = '0;
    logic [7:0] req_wdata = '0;
    logic supply_hi = 1'b1;
    logic req_ready, rsp_valid, engine_busy, asleep, chip_sel_n, out_drv_n;
    logic wr_strobe_n, deep_sleep_n, data_pins_oe_n, op_done_flag, dev_drv;
    logic [19:0] addr_pins;
    logic [7:0] rsp_rdata, data_pins_o, dev_q, bus;
    logic [7:0] last_bus = 8'h00;
    int fails = 0;
    int tests_run = 0;
    int waited;
    always #2.5 clk_sys = ~clk_sys;
    // A floating bus shows the inverse of its last level so stale data never passes
    always_comb bus = !data_pins_oe_n ? data_pins_o : (dev_drv ? dev_q : ~last_bus);
    always @(posedge clk_sys) last_bus <= bus;
    fbci_host #(.WAKE_WRITE_CYC(10), .WAKE_READ_CYC(4)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .engine_busy(engine_busy), .asleep(asleep),
        .chip_sel_n(chip_sel_n), .out_drv_n(out_drv_n), .wr_strobe_n(wr_strobe_n),
        .deep_sleep_n(deep_sleep_n), .addr_pins(addr_pins), .data_pins_o(data_pins_o),
        .data_pins_oe_n(data_pins_oe_n), .data_pins_i(bus), .op_done_flag(op_done_flag));
    fbci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (
        .chip_sel_n(chip_sel_n), .out_drv_n(out_drv_n), .wr_strobe_n(wr_strobe_n),
        .deep_sleep_n(deep_sleep_n), .program_supply_high(supply_hi),
        .addr_pins(addr_pins), .data_pins(bus), .dev_q(dev_q), .dev_drv(dev_drv),
        .op_done_flag(op_done_flag));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Contention and select are watched away from the sampling edge
    always @(negedge clk_sys) begin
        if (arst_n && !data_pins_oe_n) check({7'h00, dev_drv}, 8'h00);
        if (arst_n && !wr_strobe_n) check({7'h00, chip_sel_n}, 8'h00);
    end
    task automatic do_req(input fbci_pkg::fbci_op_t op, input logic [19:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        #1;
        waited = 0;
        while (req_ready !== 1'b1 && waited < 1000) begin
            @(posedge clk_sys);
            #1;
            waited++;
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        #1;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 1000 || waited >= 1000) check(8'h00, 8'h01);
        q = rsp_rdata;
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        logic [7:0] q;
        do_req(fbci_pkg::OP_WRITE, a, d, q);
    endtask
    task automatic rd(input logic [19:0] a, output logic [7:0] q);
        do_req(fbci_pkg::OP_READ, a, 8'h00, q);
    endtask
    task automatic wait_idle();
        logic [7:0] q;
        int k;
        wr(20'h00000, fbci_pkg::CMD_READ_STATUS);
        q = 8'h00;
        for (k = 0; k < 200 && q !== 8'h80; k++) rd(20'h00000, q);
        check(q, 8'h80);
    endtask
    task automatic t_boot();
        logic [7:0] q;
        check({chip_sel_n, wr_strobe_n, deep_sleep_n, data_pins_oe_n, 4'h0}, 8'hF0);
        rd(20'h00005, q);
        check(q, 8'hFF);
    endtask
    task automatic t_ident();
        logic [7:0] q;
        wr(20'h00000, fbci_pkg::CMD_IDENT);
        rd(fbci_pkg::IDENT_MFR_ADDR, q);
        check(q, MFR);
        rd(fbci_pkg::IDENT_DEV_ADDR, q);
        check(q, DEV);
    endtask
    task automatic t_program();
        logic [7:0] q;
        logic [7:0] codes [2] = '{fbci_pkg::CMD_PROG_SETUP, fbci_pkg::CMD_PROG_SETUP_ALT};
        logic [7:0] pats [2] = '{8'h3C, 8'hC3};
        for (int i = 0; i < 2; i++) begin
            wr(20'(16 + i), codes[i]);
            wr(20'(16 + i), pats[i]);
            check({7'h00, engine_busy}, 8'h01);
            wait_idle();
            wr(20'h00000, fbci_pkg::CMD_READ_ARRAY);
            rd(20'(16 + i), q);
            check(q, pats[i]);
        end
        @(posedge clk_sys);
        supply_hi <= 1'b0;
        wr(20'h00012, fbci_pkg::CMD_PROG_SETUP);
        wr(20'h00012, 8'h00);
        rd(20'h00012, q);
        check(q, 8'hFF);
        @(posedge clk_sys);
        supply_hi <= 1'b1;
    endtask
    task automatic t_erase();
        logic [7:0] q;
        wr(20'h00030, fbci_pkg::CMD_ERASE_SETUP);
        wr(20'h00030, fbci_pkg::CMD_CONFIRM);
        wr(20'h00000, fbci_pkg::CMD_SUSPEND);
        rd(20'h00000, q);
        check(q, 8'h80);
        check({7'h00, engine_busy}, 8'h00);
        wr(20'h00000, fbci_pkg::CMD_CONFIRM);
        check({7'h00, engine_busy}, 8'h01);
        wait_idle();
        wr(20'h00000, fbci_pkg::CMD_READ_ARRAY);
        rd(20'h00010, q);
        check(q, 8'hFF);
    endtask
    task automatic t_sleep();
        logic [7:0] q;
        wr(20'h00000, fbci_pkg::CMD_IDENT);
        wr(20'h00020, fbci_pkg::CMD_PROG_SETUP);
        wr(20'h00020, 8'h00);
        do_req(fbci_pkg::OP_SLEEP, 20'h00000, 8'h00, q);
        repeat (3) @(posedge clk_sys);
        check({6'h00, asleep, engine_busy}, 8'h02);
        do_req(fbci_pkg::OP_WAKE, 20'h00000, 8'h00, q);
        rd(fbci_pkg::IDENT_DEV_ADDR, q);
        check(q, 8'hFF);
        check({7'h00, waited > 0}, 8'h01);
        do_req(fbci_pkg::OP_SLEEP, 20'h00000, 8'h00, q);
        do_req(fbci_pkg::OP_WAKE, 20'h00000, 8'h00, q);
        wr(20'h00000, fbci_pkg::CMD_CLEAR_STATUS);
        check({7'h00, waited >= 8}, 8'h01);
        wr(20'h00000, fbci_pkg::CMD_CLEAR_STATUS);
        wr(20'h00000, fbci_pkg::CMD_READ_STATUS);
        rd(20'h00007, q);
        check(q, 8'h80);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_boot();
        t_ident();
        t_program();
        t_erase();
        t_sleep();
        tally_and_finish();
    end
    // The sequence needs about a thousand cycles; this allows over ten times that
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
